/* File: bes_channel_block.v */
// Receive and transmit two-frame elastic stores with channel blocking and code insertion.
// Assumes line and backplane clocks are far slower than core_clk (8.192 MHz worst case),
// and that serial data is stable around the rising edge of its own clock.
`timescale 1ns/1ns
`include "bes_consts.vh"
module bes_channel_block (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        line_clk,
    input  wire        rx_line_data,
    input  wire        rx_line_fsync,
    output reg         tx_line_data,
    input  wire        rx_backplane_clock,
    input  wire        rx_sync_pin_in,
    output reg         rx_sync_pin_out,
    output reg         rx_sync_pin_oe,
    output reg         rx_serial_out,
    output reg         rx_frame_marker_out,
    output reg         rx_multiframe_marker_out,
    output reg         rx_channel_block_out,
    input  wire        tx_backplane_clock,
    input  wire        tx_serial_in,
    input  wire        tx_backplane_frame_sync,
    output reg         tx_channel_block_out
);

    // T1 bit position (0 = F bit) for a backplane bit count; 0 also in filler slots
    function [8:0] map_pos;
        input [7:0] cnt;
        input       rate;
        reg   [4:0] ch;
        begin
            ch = cnt[7:3] - (cnt[7:3] >> 2) - 5'd1;
            if (!rate)
                map_pos = {1'b0, cnt};
            else if (cnt[4:3] == 2'b00)
                map_pos = 9'd0;
            else
                map_pos = {1'b0, ch, cnt[2:0]} + 9'd1;
        end
    endfunction

    function [4:0] chan_of;
        input [8:0] pos;
        reg   [8:0] p;
        begin
            p = pos - 9'd1;
            chan_of = p[7:3];
        end
    endfunction

    function [8:0] store_addr;
        input       frame;
        input [8:0] pos;
        begin
            store_addr = frame ? (`BES_FRAME_BITS + pos) : pos;
        end
    endfunction

    // Synchronisers: 0 line clk, 1 rx data, 2 line fsync, 3 rx bp clk,
    // 4 sync pin, 5 tx bp clk, 6 tx data, 7 tx fsync
    reg  [7:0] sync1_reg;
    reg  [7:0] sync2_reg;
    reg  [7:0] prev_reg;
    wire       line_rise = sync2_reg[0] & ~prev_reg[0];
    wire       rbp_rise  = sync2_reg[3] & ~prev_reg[3];
    wire       sync_rise = sync2_reg[4] & ~prev_reg[4];
    wire       tbp_rise  = sync2_reg[5] & ~prev_reg[5];

    reg  [7:0] rx_code_insert_select_low_reg;
    reg  [7:0] rx_code_insert_select_mid_reg;
    reg  [7:0] rx_code_insert_select_high_reg;
    reg  [7:0] tx_block_mask_low_reg;
    reg  [7:0] tx_block_mask_mid_reg;
    reg  [7:0] tx_block_mask_high_reg;
    reg  [7:0] rx_block_mask_low_reg;
    reg  [7:0] rx_block_mask_mid_reg;
    reg  [7:0] rx_block_mask_high_reg;
    reg  [7:0] ctrl_reg;
    reg  [7:0] status_reg;
    reg  [7:0] status_next;
    reg  [7:0] rx_channel_code [0:23];
    reg        realign_prev_reg;

    wire [23:0] rx_sel   = {rx_code_insert_select_high_reg, rx_code_insert_select_mid_reg,
                            rx_code_insert_select_low_reg};
    wire [23:0] rx_mask  = {rx_block_mask_high_reg, rx_block_mask_mid_reg,
                            rx_block_mask_low_reg};
    wire [23:0] tx_mask  = {tx_block_mask_high_reg, tx_block_mask_mid_reg,
                            tx_block_mask_low_reg};
    wire        rx_store_enable   = ctrl_reg[`BES_CTRL_RX_EN];
    wire        tx_store_enable   = ctrl_reg[`BES_CTRL_TX_EN];
    wire        rx_backplane_rate = ctrl_reg[`BES_CTRL_RX_RATE];
    wire        tx_backplane_rate = ctrl_reg[`BES_CTRL_TX_RATE];
    wire        rx_sync_direction = ctrl_reg[`BES_CTRL_SYNC_DIR];
    wire        rx_sync_mf_select = ctrl_reg[`BES_CTRL_SYNC_MF];
    wire        realign = ctrl_reg[`BES_CTRL_REALIGN] ^ realign_prev_reg;

    reg         rx_store [0:`BES_STORE_BITS-1];
    reg         tx_store [0:`BES_STORE_BITS-1];

    reg  [7:0] wcnt_reg;
    reg        wframe_reg;
    reg  [7:0] rcnt_reg;
    reg        rframe_reg;
    reg  [3:0] rmf_reg;
    reg        sync_req_reg;
    reg  [7:0] twcnt_reg;
    reg        twframe_reg;
    reg  [7:0] trcnt_reg;
    reg        trframe_reg;

    // Receive output path, shared by the store and the pass-through
    reg  [7:0] wcur;
    reg  [7:0] rcur;
    reg  [7:0] rsel_cnt;
    reg        rrate;
    reg  [8:0] rpos;
    reg  [4:0] rch;
    reg  [8:0] rbit;
    reg        rdat;
    reg        rblk;
    reg  [7:0] rlast;
    always @* begin
        wcur     = sync2_reg[2] ? 8'd0 : wcnt_reg;
        rcur     = sync_req_reg ? 8'd0 : rcnt_reg;
        rsel_cnt = rx_store_enable ? rcur : wcur;
        rrate    = rx_store_enable & rx_backplane_rate;
        rpos     = map_pos(rsel_cnt, rrate);
        rch      = chan_of(rpos);
        rbit     = rpos - 9'd1;
        rdat     = rx_store_enable ? rx_store[store_addr(rframe_reg, rpos)] : sync2_reg[1];
        rblk     = 1'b0;
        rlast    = rx_backplane_rate ? `BES_E1_LAST : `BES_T1_LAST;
        if (rpos != 9'd0) begin
            if (rx_sel[rch])
                rdat = rx_channel_code[rch][~rbit[2:0]];
            rblk = rx_mask[rch];
        end
        if (rrate && rsel_cnt[4:3] == 2'b00) begin
            rblk = 1'b1;
            if (rsel_cnt != 8'd0)
                rdat = 1'b1;
        end
    end

    reg  [7:0] tcur;
    reg  [8:0] tpos;
    reg        tfill;
    reg        tblk;
    reg  [7:0] tlast;
    always @* begin
        tcur  = sync2_reg[7] ? 8'd0 : twcnt_reg;
        tpos  = map_pos(tcur, tx_backplane_rate);
        tfill = tx_backplane_rate && tcur[4:3] == 2'b00;
        tlast = tx_backplane_rate ? `BES_E1_LAST : `BES_T1_LAST;
        tblk  = (tpos != 9'd0) ? tx_mask[chan_of(tpos)] : 1'b0;
        if (tfill)
            tblk = 1'b1;
    end

    // A bare frame compare would slip on every frame in the normal opposite-frame state
    wire rx_full_hit  = rx_store_enable && (~wframe_reg == rframe_reg) &&
                        (rcur < (rx_backplane_rate ? `BES_E1_HALF : `BES_T1_HALF));
    wire rx_empty_hit = rx_store_enable && (~rframe_reg == wframe_reg) && (wcur < `BES_T1_HALF);
    wire tx_full_hit  = tx_store_enable && (~twframe_reg == trframe_reg) &&
                        (trcnt_reg < `BES_T1_HALF);
    wire tx_empty_hit = tx_store_enable && (~trframe_reg == twframe_reg) &&
                        (tcur < (tx_backplane_rate ? `BES_E1_HALF : `BES_T1_HALF));

    reg  [31:0] rd_value;
    always @* begin
        rd_value = 32'h00000000;
        case (avs_address)
            `BES_IDX_RX_SEL_LOW:   rd_value[7:0] = rx_code_insert_select_low_reg;
            `BES_IDX_RX_SEL_MID:   rd_value[7:0] = rx_code_insert_select_mid_reg;
            `BES_IDX_RX_SEL_HIGH:  rd_value[7:0] = rx_code_insert_select_high_reg;
            `BES_IDX_TX_MASK_LOW:  rd_value[7:0] = tx_block_mask_low_reg;
            `BES_IDX_TX_MASK_MID:  rd_value[7:0] = tx_block_mask_mid_reg;
            `BES_IDX_TX_MASK_HIGH: rd_value[7:0] = tx_block_mask_high_reg;
            `BES_IDX_RX_MASK_LOW:  rd_value[7:0] = rx_block_mask_low_reg;
            `BES_IDX_RX_MASK_MID:  rd_value[7:0] = rx_block_mask_mid_reg;
            `BES_IDX_RX_MASK_HIGH: rd_value[7:0] = rx_block_mask_high_reg;
            `BES_IDX_CTRL:         rd_value[7:0] = ctrl_reg;
            `BES_IDX_STATUS:       rd_value[7:0] = status_reg;
            default: begin
                if (avs_address >= `BES_IDX_CODE_A_FIRST && avs_address <= `BES_IDX_CODE_A_LAST)
                    rd_value[7:0] = rx_channel_code[avs_address[2:0]];
                else if (avs_address >= `BES_IDX_CODE_B_FIRST &&
                         avs_address <= `BES_IDX_CODE_B_LAST)
                    rd_value[7:0] = rx_channel_code[{1'b0, avs_address[3:0]} + 5'd8];
            end
        endcase
    end

    wire bus_req = avs_read | avs_write;
    wire wr_go   = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    integer i;

    // Slip events gathered per cycle; set wins over a software clear
    reg [7:0] st_set;
    always @* begin
        st_set = 8'h00;
        if (clk_en && line_rise && wcur == `BES_T1_LAST && rx_full_hit && !realign) begin
            st_set[`BES_ST_RX_SLIP] = 1'b1;
            st_set[`BES_ST_RX_FULL] = 1'b1;
        end
        if (clk_en && rbp_rise && rcur == rlast && rx_empty_hit && !realign) begin
            st_set[`BES_ST_RX_SLIP]  = 1'b1;
            st_set[`BES_ST_RX_EMPTY] = 1'b1;
        end
        if (clk_en && tbp_rise && tcur == tlast && tx_full_hit && !realign) begin
            st_set[`BES_ST_TX_SLIP]  = 1'b1;
            st_set[`BES_ST_TX_DIR_A] = 1'b1;
        end
        if (clk_en && line_rise && trcnt_reg == `BES_T1_LAST && tx_empty_hit && !realign) begin
            st_set[`BES_ST_TX_SLIP]  = 1'b1;
            st_set[`BES_ST_TX_DIR_B] = 1'b1;
        end
        status_next = status_reg | st_set;
        if (wr_go && avs_address == `BES_IDX_STATUS)
            status_next = (status_reg & ~wbyte) | st_set;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            prev_reg <= 8'h00;
            rx_code_insert_select_low_reg <= `BES_RESET_BYTE;
            rx_code_insert_select_mid_reg <= `BES_RESET_BYTE;
            rx_code_insert_select_high_reg <= `BES_RESET_BYTE;
            tx_block_mask_low_reg <= `BES_RESET_BYTE;
            tx_block_mask_mid_reg <= `BES_RESET_BYTE;
            tx_block_mask_high_reg <= `BES_RESET_BYTE;
            rx_block_mask_low_reg <= `BES_RESET_BYTE;
            rx_block_mask_mid_reg <= `BES_RESET_BYTE;
            rx_block_mask_high_reg <= `BES_RESET_BYTE;
            ctrl_reg <= `BES_RESET_BYTE;
            status_reg <= `BES_RESET_BYTE;
            realign_prev_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
            wcnt_reg <= 8'h00;
            wframe_reg <= 1'b0;
            rcnt_reg <= 8'h00;
            rframe_reg <= 1'b1;
            rmf_reg <= 4'h0;
            sync_req_reg <= 1'b0;
            twcnt_reg <= 8'h00;
            twframe_reg <= 1'b0;
            trcnt_reg <= 8'h00;
            trframe_reg <= 1'b1;
            tx_line_data <= 1'b0;
            rx_sync_pin_out <= 1'b0;
            rx_sync_pin_oe <= 1'b0;
            rx_serial_out <= 1'b1;
            rx_frame_marker_out <= 1'b0;
            rx_multiframe_marker_out <= 1'b0;
            rx_channel_block_out <= 1'b0;
            tx_channel_block_out <= 1'b0;
            for (i = 0; i < 24; i = i + 1)
                rx_channel_code[i] <= `BES_RESET_BYTE;
        end else if (clk_en) begin
            sync1_reg <= {tx_backplane_frame_sync, tx_serial_in, tx_backplane_clock,
                          rx_sync_pin_in, rx_backplane_clock, rx_line_fsync,
                          rx_line_data, line_clk};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            status_reg <= status_next;
            realign_prev_reg <= ctrl_reg[`BES_CTRL_REALIGN];

            // One wait state, then the answer edge
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            avs_readdata <= rd_value;
            if (wr_go) begin
                case (avs_address)
                    `BES_IDX_RX_SEL_LOW:   rx_code_insert_select_low_reg <= wbyte;
                    `BES_IDX_RX_SEL_MID:   rx_code_insert_select_mid_reg <= wbyte;
                    `BES_IDX_RX_SEL_HIGH:  rx_code_insert_select_high_reg <= wbyte;
                    `BES_IDX_TX_MASK_LOW:  tx_block_mask_low_reg <= wbyte;
                    `BES_IDX_TX_MASK_MID:  tx_block_mask_mid_reg <= wbyte;
                    `BES_IDX_TX_MASK_HIGH: tx_block_mask_high_reg <= wbyte;
                    `BES_IDX_RX_MASK_LOW:  rx_block_mask_low_reg <= wbyte;
                    `BES_IDX_RX_MASK_MID:  rx_block_mask_mid_reg <= wbyte;
                    `BES_IDX_RX_MASK_HIGH: rx_block_mask_high_reg <= wbyte;
                    `BES_IDX_CTRL:         ctrl_reg <= wbyte;
                    default: begin
                        if (avs_address >= `BES_IDX_CODE_A_FIRST &&
                            avs_address <= `BES_IDX_CODE_A_LAST)
                            rx_channel_code[avs_address[2:0]] <= wbyte;
                        else if (avs_address >= `BES_IDX_CODE_B_FIRST &&
                                 avs_address <= `BES_IDX_CODE_B_LAST)
                            rx_channel_code[{1'b0, avs_address[3:0]} + 5'd8] <= wbyte;
                    end
                endcase
            end

            rx_sync_pin_oe <= ~rx_sync_direction;
            if (rx_sync_direction && sync_rise)
                sync_req_reg <= 1'b1;

            // Receive write side, line clock
            if (line_rise) begin
                rx_store[store_addr(wframe_reg, {1'b0, wcur})] <= sync2_reg[1];
                if (wcur == `BES_T1_LAST) begin
                    wcnt_reg <= 8'h00;
                    if (!rx_full_hit)
                        wframe_reg <= ~wframe_reg;
                end else begin
                    wcnt_reg <= wcur + 8'd1;
                end
                if (!rx_store_enable) begin
                    rx_serial_out <= rdat;
                    rx_channel_block_out <= rblk;
                    rx_frame_marker_out <= (wcur == 8'd0);
                    rx_multiframe_marker_out <= 1'b0;
                    rx_sync_pin_out <= ~rx_sync_direction & (wcur == 8'd0);
                end
            end

            // Receive read side, backplane clock
            if (rx_store_enable && rbp_rise) begin
                sync_req_reg <= 1'b0;
                rx_serial_out <= rdat;
                rx_channel_block_out <= rblk;
                rx_frame_marker_out <= (rcur == 8'd0);
                rx_multiframe_marker_out <= (rcur == 8'd0) && (rmf_reg == 4'h0);
                rx_sync_pin_out <= ~rx_sync_direction && (rcur == 8'd0) &&
                                   (!rx_sync_mf_select || rmf_reg == 4'h0);
                if (sync_req_reg && rx_sync_mf_select)
                    rmf_reg <= 4'h0;
                if (rcur == rlast) begin
                    rcnt_reg <= 8'h00;
                    rmf_reg <= (rmf_reg == `BES_MF_LAST) ? 4'h0 : rmf_reg + 4'h1;
                    if (!rx_empty_hit)
                        rframe_reg <= ~rframe_reg;
                end else begin
                    rcnt_reg <= rcur + 8'd1;
                end
            end

            // Transmit write side, backplane clock
            if (tbp_rise) begin
                tx_channel_block_out <= tblk;
                if (!tfill || tcur == 8'd0)
                    tx_store[store_addr(twframe_reg, tpos)] <= sync2_reg[6];
                if (tcur == tlast) begin
                    twcnt_reg <= 8'h00;
                    if (!tx_full_hit)
                        twframe_reg <= ~twframe_reg;
                end else begin
                    twcnt_reg <= tcur + 8'd1;
                end
            end

            // Transmit read side, line clock
            if (line_rise) begin
                tx_line_data <= tx_store_enable ?
                                tx_store[store_addr(trframe_reg, {1'b0, trcnt_reg})] :
                                sync2_reg[6];
                if (trcnt_reg == `BES_T1_LAST) begin
                    trcnt_reg <= 8'h00;
                    if (!tx_empty_hit)
                        trframe_reg <= ~trframe_reg;
                end else begin
                    trcnt_reg <= trcnt_reg + 8'd1;
                end
            end

            if (realign) begin
                rframe_reg <= ~wframe_reg;
                rcnt_reg <= 8'h00;
                trframe_reg <= ~twframe_reg;
                trcnt_reg <= 8'h00;
            end
        end
    end

endmodule // bes_channel_block

/* File: bes_consts.vh */
// Constants for the backplane elastic store channel block.
// Register indices are Avalon word addresses; byte address is four times the index.
`ifndef BES_CONSTS_VH
`define BES_CONSTS_VH
`define BES_IDX_RX_SEL_LOW   8'h1B
`define BES_IDX_RX_SEL_MID   8'h1C
`define BES_IDX_RX_SEL_HIGH  8'h1D
`define BES_IDX_TX_MASK_LOW  8'h32
`define BES_IDX_TX_MASK_MID  8'h33
`define BES_IDX_TX_MASK_HIGH 8'h34
`define BES_IDX_RX_MASK_LOW  8'h6C
`define BES_IDX_RX_MASK_MID  8'h6D
`define BES_IDX_RX_MASK_HIGH 8'h6E
`define BES_IDX_CODE_A_FIRST 8'h58
`define BES_IDX_CODE_A_LAST  8'h5F
`define BES_IDX_CODE_B_FIRST 8'h80
`define BES_IDX_CODE_B_LAST  8'h8F
`define BES_IDX_CTRL         8'h90
`define BES_IDX_STATUS       8'h91
`define BES_CTRL_RX_EN       0
`define BES_CTRL_TX_EN       1
`define BES_CTRL_RX_RATE     2
`define BES_CTRL_TX_RATE     3
`define BES_CTRL_REALIGN     4
`define BES_CTRL_SYNC_DIR    5
`define BES_CTRL_SYNC_MF     6
`define BES_ST_RX_SLIP       0
`define BES_ST_RX_EMPTY      1
`define BES_ST_RX_FULL       2
`define BES_ST_TX_SLIP       3
`define BES_ST_TX_DIR_A      4
`define BES_ST_TX_DIR_B      5
`define BES_RESET_BYTE       8'h00
`define BES_FRAME_BITS       9'd193
`define BES_STORE_BITS       386
`define BES_T1_LAST          8'd192
`define BES_E1_LAST          8'd255
`define BES_MF_LAST          4'd11
`define BES_T1_HALF          8'd96
`define BES_E1_HALF          8'd128
`endif

/* File: bes_monitor.sv */
// Port checker for the channel block: bus handshake, markers, reset.
// Assumes clk_en stays high while it watches.
`timescale 1ns/1ns
module bes_monitor (
    input logic        core_clk,
    input logic        rst_n,
    input logic        clk_en,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic        line_clk,
    input logic        rx_serial_out,
    input logic        rx_frame_marker_out,
    input logic        rx_multiframe_marker_out,
    input logic        tx_line_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");
    a_rdata_upper: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("readdata upper bits set");
    a_reset_vals: assert property (disable iff (1'b0) !rst_n && clk_en |=> avs_waitrequest && rx_serial_out && !rx_frame_marker_out)
        else $error("reset values wrong");
    a_marker_len: assert property ($rose(rx_frame_marker_out) |-> rx_frame_marker_out[*8] ##[1:40] !rx_frame_marker_out)
        else $error("frame marker length wrong");
    a_mf_frame: assert property (rx_multiframe_marker_out |-> rx_frame_marker_out)
        else $error("multiframe marker off frame start");
    a_tx_stable: assert property ((!line_clk)[*5] |-> $stable(tx_line_data))
        else $error("transmit data moved off line edge");
endmodule // bes_monitor
bind bes_channel_block bes_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_clk(line_clk), .rx_serial_out(rx_serial_out),
    .rx_frame_marker_out(rx_frame_marker_out), .tx_line_data(tx_line_data),
    .rx_multiframe_marker_out(rx_multiframe_marker_out));

/* File: bes_backplane_model.sv */
// Line and backplane partner: free-running clocks, framed serial data.
// Data moves on falling edges so it is settled at each rising edge.
`timescale 1ns/1ns
module bes_backplane_model (
    input  logic tx_e1,
    output logic line_clk,
    output logic rx_line_data,
    output logic rx_line_fsync,
    output logic rx_backplane_clock,
    output logic tx_backplane_clock,
    output logic tx_serial_in,
    output logic tx_backplane_frame_sync,
    output logic rx_sync_pin_in
);
    int lbit = 0;
    int tbit = 0;
    initial begin
        {line_clk, rx_line_data, rx_line_fsync, tx_serial_in, tx_backplane_frame_sync} = 5'h00;
        {rx_backplane_clock, tx_backplane_clock, rx_sync_pin_in} = 3'h0;
    end
    // Line faster than T1 to keep the run short
    // Offset so no link edge meets a core edge
    initial begin
        #2;
        forever #125 line_clk = ~line_clk;
    end
    always @(negedge line_clk) begin
        lbit = (lbit == 192) ? 0 : lbit + 1;
        rx_line_fsync = (lbit == 0);
        rx_line_data = (lbit == 0);
    end
    initial begin
        #1;
        forever begin
            #62 {rx_backplane_clock, tx_backplane_clock} = 2'h3;
            #63 {rx_backplane_clock, tx_backplane_clock} = 2'h0;
        end
    end
    always @(negedge tx_backplane_clock) begin
        tbit = (tbit >= (tx_e1 ? 255 : 192)) ? 0 : tbit + 1;
        tx_backplane_frame_sync = (tbit == 0);
        tx_serial_in = tx_e1 && ((tbit / 8) % 4 == 0) && (tbit != 0);
    end
endmodule // bes_backplane_model

/* File: bes_channel_block_tb_top.sv */
// Bench for the channel block: registers, blocking, insertion, slips.
// Assumes the backplane model supplies line and backplane traffic.
`timescale 1ns/1ns
module bes_channel_block_tb_top;
    logic        core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, tx_e1 = 0;
    logic [7:0]  avs_address = 8'h00, q;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_waitrequest, line_clk, rx_line_data, rx_line_fsync, tx_line_data;
    logic        rx_backplane_clock, rx_sync_pin_in, rx_sync_pin_out, rx_sync_pin_oe;
    logic        rx_serial_out, rx_frame_marker_out, rx_multiframe_marker_out;
    logic        rx_channel_block_out, tx_backplane_clock, tx_serial_in;
    logic        tx_backplane_frame_sync, tx_channel_block_out;
    int          failures = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    bes_channel_block dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_clk(line_clk),
        .rx_line_data(rx_line_data), .rx_line_fsync(rx_line_fsync), .tx_line_data(tx_line_data),
        .rx_backplane_clock(rx_backplane_clock), .rx_sync_pin_in(rx_sync_pin_in),
        .rx_sync_pin_out(rx_sync_pin_out), .rx_sync_pin_oe(rx_sync_pin_oe),
        .rx_serial_out(rx_serial_out), .rx_frame_marker_out(rx_frame_marker_out),
        .rx_multiframe_marker_out(rx_multiframe_marker_out),
        .rx_channel_block_out(rx_channel_block_out), .tx_backplane_clock(tx_backplane_clock),
        .tx_serial_in(tx_serial_in), .tx_backplane_frame_sync(tx_backplane_frame_sync),
        .tx_channel_block_out(tx_channel_block_out));
    bes_backplane_model bpm (.tx_e1(tx_e1), .line_clk(line_clk), .rx_line_data(rx_line_data),
        .rx_line_fsync(rx_line_fsync), .rx_backplane_clock(rx_backplane_clock),
        .tx_backplane_clock(tx_backplane_clock), .tx_serial_in(tx_serial_in),
        .tx_backplane_frame_sync(tx_backplane_frame_sync), .rx_sync_pin_in(rx_sync_pin_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) failures++;
    endtask
    // Counts ones over n bit times of the chosen output
    task automatic cnt(input int sel, input int n, output int k);
        k = 0;
        repeat (n) begin
            if (sel < 2) @(posedge rx_backplane_clock);
            else if (sel == 2) @(posedge tx_backplane_clock);
            else @(posedge line_clk);
            case (sel)
                0: k += (rx_channel_block_out === 1'b1);
                1: k += (rx_serial_out === 1'b1);
                2: k += (tx_channel_block_out === 1'b1);
                default: k += (tx_line_data === 1'b1);
            endcase
        end
    endtask
    task automatic t_regs;
        logic [7:0] idx [10] = '{8'h1B, 8'h1C, 8'h1D, 8'h32, 8'h33, 8'h34, 8'h6C, 8'h6D,
                                 8'h6E, 8'h90};
        foreach (idx[i]) begin
            bus(0, idx[i], 8'h00, 4'h1);
            check(q, 8'h00);
            bus(1, idx[i], idx[i] ^ 8'h5A, 4'h1);
            bus(0, idx[i], 8'h00, 4'h1);
            check(q, idx[i] ^ 8'h5A);
            bus(1, idx[i], 8'h00, 4'h1);
        end
        bus(1, 8'h00, 8'hFF, 4'h1);
        bus(0, 8'h00, 8'h00, 4'h1);
        check(q, 8'h00);
        bus(1, 8'h6C, 8'hFF, 4'h0);
        bus(0, 8'h6C, 8'h00, 4'h1);
        check(q, 8'h00);
    endtask
    // Store off: channel 1 and 24 blocked and replaced by codes
    task automatic t_rx_t1;
        logic [192:0] blk;
        int ones, n, k;
        bus(1, 8'h6C, 8'h01, 4'h1);
        bus(1, 8'h6E, 8'h80, 4'h1);
        bus(1, 8'h1B, 8'h01, 4'h1);
        bus(1, 8'h1D, 8'h80, 4'h1);
        bus(1, 8'h58, 8'hA5, 4'h1);
        bus(1, 8'h8F, 8'h81, 4'h1);
        cnt(3, 200, k);
        check(rx_sync_pin_oe, 1'b1);
        n = 0;
        do begin
            @(posedge line_clk);
            n++;
        end while (rx_frame_marker_out !== 1'b1 && n < 400);
        check(rx_sync_pin_out, 1'b1);
        ones = 0;
        for (int i = 0; i < 193; i++) begin
            blk[i] = rx_channel_block_out;
            ones += (rx_serial_out === 1'b1);
            if (i < 192) @(posedge line_clk);
        end
        check(blk[8:0], 9'h1FE);
        check(blk[192:184], 9'h1FE);
        check($countones(blk), 16);
        check(ones, 7);
    endtask
    // Both stores on at 2.048: filler slots, slips in both directions
    task automatic t_e1;
        int k;
        tx_e1 = 1'b1;
        bus(1, 8'h32, 8'h0F, 4'h1);
        bus(1, 8'h90, 8'h2F, 4'h1);
        cnt(3, 400, k);
        check(rx_sync_pin_oe, 1'b0);
        // Start-up slips cleared; later ones come from the rate gap alone
        bus(1, 8'h91, 8'hFF, 4'h1);
        cnt(0, 256, k);
        check(k, 80);
        cnt(1, 256, k);
        check(k, 70);
        cnt(2, 256, k);
        check(k, 96);
        cnt(3, 193, k);
        check(k, 0);
        cnt(3, 200, k);
        bus(0, 8'h91, 8'h00, 4'h1);
        check(q, 8'h1B);
    endtask
    // Transmit store alone at 1.544 after a realign toggle
    task automatic t_tx_t1;
        int k;
        tx_e1 = 1'b0;
        bus(1, 8'h90, 8'h02, 4'h1);
        bus(1, 8'h90, 8'h12, 4'h1);
        cnt(3, 400, k);
        cnt(2, 193, k);
        check(k, 32);
    endtask
    initial begin
        #1_000_000;
        failures++;
        close_out;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_rx_t1;
        t_e1;
        t_tx_t1;
        close_out;
    end
endmodule // bes_channel_block_tb_top
